// [logic/timer_pkg.sv]
// timer package: register map, field positions, reset values, modes
// assumes a wishbone classic slave with 32-bit data, byte addresses
// Behaviour
// - counter and both compares are eight bits
// - every timer request readable in flag register
// - each request masked by its own bit
// - overflow, compare a, compare b sources
// - tick from prescaled io clock or crystal
// - clock select stage forms the timer tick
// - no source selected means no counting, events
// - async clock select resets to zero
// - async select one switches to crystal clock
// - compares double buffered in pwm modes, compared on each tick
// - compare result drives outputs a and b
// - match sets the matching compare flag
// - zero is the bottom condition
// - 255 is the maximum condition
// - top is 255 or compare a
// - select zero stops, counter stays accessible
// - processor counter write beats clear or count
package timer_pkg;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] BOTTOM_VAL = 8'h00;
    localparam logic [CNT_W-1:0] MAX_VAL = 8'hFF;
    localparam logic [CNT_W-1:0] ZERO_VAL = 8'h00;
    // register byte offsets
    localparam logic [4:0] OFS_COUNT = 5'h00;
    localparam logic [4:0] OFS_CMPA = 5'h04;
    localparam logic [4:0] OFS_CMPB = 5'h08;
    localparam logic [4:0] OFS_CTRL = 5'h0C;
    localparam logic [4:0] OFS_FLAG = 5'h10;
    localparam logic [4:0] OFS_FCLR = 5'h14;
    localparam logic [4:0] OFS_MASK = 5'h18;
    localparam logic [4:0] OFS_ASYNC = 5'h1C;
    // control field positions
    localparam int CS_LSB = 0;
    localparam int WGM_LSB = 3;
    localparam int COMA_LSB = 6;
    localparam int COMB_LSB = 8;
    localparam int PRR_BIT = 10;
    // flag and mask bit positions
    localparam int FLG_OVF = 0;
    localparam int FLG_CMPA = 1;
    localparam int FLG_CMPB = 2;
    localparam int N_FLG = 3;
    // clock source select codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV32 = 3'h3;
    localparam logic [2:0] CS_DIV64 = 3'h4;
    localparam logic [2:0] CS_DIV128 = 3'h5;
    localparam logic [2:0] CS_DIV256 = 3'h6;
    localparam logic [2:0] CS_DIV1024 = 3'h7;
    // waveform modes
    localparam logic [2:0] WGM_NORMAL = 3'h0;
    localparam logic [2:0] WGM_CTC = 3'h2;
    localparam logic [2:0] WGM_FAST = 3'h3;
    localparam logic [2:0] WGM_FAST_A = 3'h7;
    // compare output actions
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
    localparam int PRESC_W = 10;
    localparam int CTRL_W = 11;
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h400;
endpackage

// [logic/tick_select.sv]
// tick_select: prescaler and clock source select forming the timer tick
// assumes the crystal input is already synchronised to i_clk
`timescale 1ns/1ps
module tick_select
    import timer_pkg::*;
#(
    parameter int PW = PRESC_W
) (
    input wire logic i_clk, // system clock
    input wire logic i_reset_n, // sync reset, low active
    input wire logic i_ce, // clock enable
    input wire logic i_run, // module enabled
    input wire logic i_async_sel, // crystal as source
    input wire logic i_xtal_sync, // synchronised crystal level
    input wire logic [2:0] i_cs, // clock source select
    output logic o_tick // one-cycle timer tick
);
    typedef struct packed {
        logic [PW-1:0] presc;
        logic xtal_prev;
    } tsel_state_t;
    tsel_state_t s_q, s_d;
    logic base_tick;
    logic [PW-1:0] nxt;

    // free running prescaler fed by io clock or crystal edges
    always_comb begin
        nxt = s_q.presc + {{(PW-1){1'b0}}, 1'b1};
        s_d = s_q;
        s_d.xtal_prev = i_xtal_sync;
        base_tick = i_async_sel ? (i_xtal_sync & ~s_q.xtal_prev) : 1'b1;
        if (base_tick && i_run) begin
            s_d.presc = nxt;
        end
    end

    // tap where all lower prescaler bits roll over on this base tick
    function automatic logic tap(input logic [PW-1:0] p, input int bits);
        logic [PW-1:0] m;
        m = PW'((1 << bits) - 1);
        return (p & m) == m;
    endfunction

    always_comb begin
        unique case (i_cs)
            CS_DIV1: o_tick = 1'b1;
            CS_DIV8: o_tick = tap(s_q.presc, 3);
            CS_DIV32: o_tick = tap(s_q.presc, 5);
            CS_DIV64: o_tick = tap(s_q.presc, 6);
            CS_DIV128: o_tick = tap(s_q.presc, 7);
            CS_DIV256: o_tick = tap(s_q.presc, 8);
            CS_DIV1024: o_tick = tap(s_q.presc, 10);
            CS_STOP: o_tick = 1'b0;
        endcase
        o_tick = o_tick & base_tick & i_run & i_ce;
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            s_q <= '0;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end
endmodule

// [logic/timer_core.sv]
// timer_core: 8-bit timer counter with two compares, flags, wishbone regs
// assumes a classic wishbone master on i_clk; crystal arrives on a pin
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps
module timer_core
    import timer_pkg::*;
(
    input wire logic i_clk, // 200 MHz system clock
    input wire logic i_reset_n, // sync reset, low active
    input wire logic i_ce, // clock enable, freezes state
    input wire logic i_wb_cyc, // bus cycle
    input wire logic i_wb_stb, // bus strobe
    input wire logic i_wb_we, // write enable
    input wire logic [4:0] i_wb_adr, // byte address
    input wire logic [3:0] i_wb_sel, // byte lanes
    input wire logic [31:0] i_wb_dat, // write data
    input wire logic i_crystal_osc_in, // crystal clock pin
    output logic [31:0] o_wb_dat, // read data
    output logic o_wb_ack, // bus acknowledge
    output logic o_compare_output_a, // waveform output a
    output logic o_compare_output_b, // waveform output b
    output logic o_irq // level interrupt
);
    // ***************************************************************
    // state
    // ***************************************************************
    typedef struct packed {
        logic [CNT_W-1:0] count_value_reg;
        logic [CNT_W-1:0] cmpa_buf;
        logic [CNT_W-1:0] cmpb_buf;
        logic [CNT_W-1:0] compare_a_value;
        logic [CNT_W-1:0] compare_b_value;
        logic [CTRL_W-1:0] ctrl;
        logic async_clock_select;
        logic [N_FLG-1:0] timer_flag_register;
        logic [N_FLG-1:0] timer_mask_register;
        logic match_a_pend;
        logic match_b_pend;
        logic out_a;
        logic out_b;
        logic irq;
        logic ack;
        logic [31:0] rdat;
        logic [1:0] xsync;
    } core_state_t;
    core_state_t s_q, s_d;

    logic tick;
    logic [2:0] cs, wgm;
    logic [1:0] coma, comb;
    logic run, pwm_mode, at_top, bus_req, wr;
    logic [CNT_W-1:0] top_val;
    logic [N_FLG-1:0] ev;

    assign cs = s_q.ctrl[CS_LSB +: 3];
    assign wgm = s_q.ctrl[WGM_LSB +: 3];
    assign coma = s_q.ctrl[COMA_LSB +: 2];
    assign comb = s_q.ctrl[COMB_LSB +: 2];
    assign run = ~s_q.ctrl[PRR_BIT]; // module idle while power bit set
    assign pwm_mode = (wgm == WGM_FAST) || (wgm == WGM_FAST_A);
    assign top_val = (wgm == WGM_FAST_A || wgm == WGM_CTC) ? s_q.compare_a_value
                                                           : MAX_VAL;
    assign at_top = (s_q.count_value_reg == top_val);
    assign bus_req = i_wb_cyc & i_wb_stb & ~s_q.ack;
    assign wr = bus_req & i_wb_we;

    // ***************************************************************
    // tick generation
    // ***************************************************************
    tick_select u_tick (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_ce(i_ce),
        .i_run(run),
        .i_async_sel(s_q.async_clock_select),
        .i_xtal_sync(s_q.xsync[1]),
        .i_cs(cs),
        .o_tick(tick)
    );

    // merge a write into a register honouring byte lanes
    function automatic logic [CNT_W-1:0] lane0(input logic [CNT_W-1:0] old);
        return i_wb_sel[0] ? i_wb_dat[CNT_W-1:0] : old;
    endfunction

    function automatic logic hit(input logic [4:0] ofs);
        return wr && (i_wb_adr == ofs);
    endfunction

    // ***************************************************************
    // next state
    // ***************************************************************
    always_comb begin
        s_d = s_q;
        ev = '0;
        // crystal pin passes two flops before use
        s_d.xsync = {s_q.xsync[0], i_crystal_osc_in};
        // compare flags raised in the tick after the match was seen, overflow in the tick that leaves max or top
        if (tick) begin
            ev[FLG_CMPA] = s_q.match_a_pend;
            ev[FLG_CMPB] = s_q.match_b_pend;
            s_d.match_a_pend = (s_q.count_value_reg == s_q.compare_a_value);
            s_d.match_b_pend = (s_q.count_value_reg == s_q.compare_b_value);
            // counting: clear at top in ctc/fast-a, else wrap at max
            if (at_top && wgm != WGM_NORMAL && wgm != WGM_FAST) begin
                s_d.count_value_reg = BOTTOM_VAL;
            end else begin
                s_d.count_value_reg = s_q.count_value_reg + 8'h01;
            end
            // overflow when leaving max (normal/ctc) or top (fast pwm)
            ev[FLG_OVF] = pwm_mode ? at_top : (s_q.count_value_reg == MAX_VAL);
            // double buffer update at top in pwm, immediate otherwise
            if (pwm_mode && at_top) begin
                s_d.compare_a_value = s_q.cmpa_buf;
                s_d.compare_b_value = s_q.cmpb_buf;
            end
            // waveform outputs
            if (s_q.match_a_pend) begin
                unique case (coma)
                    COM_TOGGLE: s_d.out_a = ~s_q.out_a;
                    COM_CLEAR: s_d.out_a = 1'b0;
                    COM_SET: s_d.out_a = 1'b1;
                    default: s_d.out_a = s_q.out_a;
                endcase
            end else if (pwm_mode && at_top && coma[1]) begin
                s_d.out_a = ~coma[0];
            end
            if (s_q.match_b_pend) begin
                unique case (comb)
                    COM_TOGGLE: s_d.out_b = ~s_q.out_b;
                    COM_CLEAR: s_d.out_b = 1'b0;
                    COM_SET: s_d.out_b = 1'b1;
                    default: s_d.out_b = s_q.out_b;
                endcase
            end else if (pwm_mode && at_top && comb[1]) begin
                s_d.out_b = ~comb[0];
            end
        end
        if (!pwm_mode) begin
            s_d.compare_a_value = s_q.cmpa_buf;
            s_d.compare_b_value = s_q.cmpb_buf;
        end
        // register writes; counter write overrides count and clear
        if (hit(OFS_COUNT)) begin
            s_d.count_value_reg = lane0(s_q.count_value_reg);
        end
        if (hit(OFS_CMPA)) begin
            s_d.cmpa_buf = lane0(s_q.cmpa_buf);
        end
        if (hit(OFS_CMPB)) begin
            s_d.cmpb_buf = lane0(s_q.cmpb_buf);
        end
        if (hit(OFS_CTRL)) begin
            if (i_wb_sel[0]) begin
                s_d.ctrl[7:0] = i_wb_dat[7:0];
            end
            if (i_wb_sel[1]) begin
                s_d.ctrl[CTRL_W-1:8] = i_wb_dat[CTRL_W-1:8];
            end
        end
        if (hit(OFS_MASK) && i_wb_sel[0]) begin
            s_d.timer_mask_register = i_wb_dat[N_FLG-1:0];
        end
        if (hit(OFS_ASYNC) && i_wb_sel[0]) begin
            s_d.async_clock_select = i_wb_dat[0];
        end
        // sticky flags: write one clears, a same-cycle event wins
        if (hit(OFS_FCLR) && i_wb_sel[0]) begin
            s_d.timer_flag_register = s_q.timer_flag_register & ~i_wb_dat[N_FLG-1:0];
        end
        s_d.timer_flag_register = s_d.timer_flag_register | ev;
        s_d.irq = |(s_d.timer_flag_register & s_d.timer_mask_register);
        // reads
        s_d.ack = bus_req;
        s_d.rdat = '0;
        if (bus_req && !i_wb_we) begin
            unique case (i_wb_adr)
                OFS_COUNT: s_d.rdat[CNT_W-1:0] = s_q.count_value_reg;
                OFS_CMPA: s_d.rdat[CNT_W-1:0] = s_q.cmpa_buf;
                OFS_CMPB: s_d.rdat[CNT_W-1:0] = s_q.cmpb_buf;
                OFS_CTRL: s_d.rdat[CTRL_W-1:0] = s_q.ctrl;
                OFS_FLAG: s_d.rdat[N_FLG-1:0] = s_q.timer_flag_register;
                OFS_MASK: s_d.rdat[N_FLG-1:0] = s_q.timer_mask_register;
                OFS_ASYNC: s_d.rdat[0] = s_q.async_clock_select;
                default: s_d.rdat = '0; // unmapped and clear reg read zero
            endcase
        end
    end

    // ***************************************************************
    // registers
    // ***************************************************************
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            s_q <= '0;
            s_q.ctrl <= CTRL_RST;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    assign o_wb_dat = s_q.rdat;
    assign o_wb_ack = s_q.ack;
    assign o_compare_output_a = s_q.out_a;
    assign o_compare_output_b = s_q.out_b;
    assign o_irq = s_q.irq;

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n || !i_ce);

    a_stop_no_count: assert property (
        (cs == CS_STOP && !(wr && i_wb_adr == OFS_COUNT)) |=> $stable(s_q.count_value_reg))
        else $error("counter moved with no clock source");
    a_write_wins: assert property (
        (wr && i_wb_adr == OFS_COUNT && i_wb_sel[0])
        |=> s_q.count_value_reg == $past(i_wb_dat[CNT_W-1:0]))
        else $error("counter write lost");
    a_ovf_flag_set: assert property (
        (tick && !pwm_mode && s_q.count_value_reg == MAX_VAL) |=> s_q.timer_flag_register[FLG_OVF])
        else $error("overflow flag not set");
    a_cmpa_flag_set: assert property (
        (tick && s_q.match_a_pend) |=> s_q.timer_flag_register[FLG_CMPA])
        else $error("compare a flag not set");
    a_flag_sticky: assert property (
        (s_q.timer_flag_register[FLG_CMPB] && !(wr && i_wb_adr == OFS_FCLR))
        |=> s_q.timer_flag_register[FLG_CMPB])
        else $error("flag dropped without clear");
    a_irq_masked: assert property (
        o_irq == |(s_q.timer_flag_register & s_q.timer_mask_register))
        else $error("irq not flag and mask");
    a_ctc_clear: assert property (
        (tick && wgm == WGM_CTC && at_top && !(wr && i_wb_adr == OFS_COUNT))
        |=> s_q.count_value_reg == BOTTOM_VAL)
        else $error("ctc did not clear at top");
    a_power_off: assert property (
        !run |-> !tick)
        else $error("tick while powered down");
    a_ack_one: assert property (
        o_wb_ack |=> !o_wb_ack)
        else $error("ack held two cycles");

    c_overflow: cover property (s_q.timer_flag_register[FLG_OVF]);
    c_cmpb_irq: cover property (o_irq && s_q.timer_flag_register[FLG_CMPB]);
    c_async_tick: cover property (s_q.async_clock_select && tick);
    c_pwm_out_b: cover property (pwm_mode && o_compare_output_b);
endmodule

// [testbench/async_timer_counter_core_tb_top.sv]
// bench for timer_core: register access, counting, flags, irq, crystal tick
// assumes classic wishbone with one-cycle ack; i_ce high except in the freeze test
`timescale 1ns/1ps
module async_timer_counter_core_tb_top;
    import timer_pkg::*;
    logic i_clk = 1'b0, i_reset_n = 1'b0, i_ce = 1'b1, xtal = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic ack, out_a, out_b, irq;
    int err_total = 0, samples_checked = 0;
    timer_core uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .i_crystal_osc_in(xtal), .o_wb_dat(rdat), .o_wb_ack(ack),
        .o_compare_output_a(out_a), .o_compare_output_b(out_b), .o_irq(irq));
    // ************************************************************
    // clock, watchdog and shared tasks
    // ************************************************************
    initial begin
        forever #2.5 i_clk = ~i_clk;
    end
    // whole run is a few thousand cycles; 20000 leaves ample slack
    initial begin
        #100000;
        err_total++;
        report_and_stop();
    end
    task automatic report_and_stop();
        $display("counts: checked=%0d mismatches=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // request held until ack is sampled high, then released; one idle cycle follows
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge i_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge i_clk);
        while (ack !== 1'b1) @(posedge i_clk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    function automatic logic [31:0] ctrl(input logic [2:0] cs, input logic [2:0] wgm,
        input logic [1:0] coma);
        return (32'(cs) << CS_LSB) | (32'(wgm) << WGM_LSB) | (32'(coma) << COMA_LSB);
    endfunction
    task automatic idle(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        logic [31:0] exp [8] = '{32'h0, 32'h0, 32'h0, 32'h400, 32'h0, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, 5'(i * 4), 32'h0);
            chk(q, exp[i]);
        end
        wb(1'b1, OFS_COUNT, 32'h1FF);
        wb(1'b0, OFS_COUNT, 32'h0);
        chk(q, 32'hFF);
        $display("test reset values done");
    endtask
    // power bit still set: selected source must not advance the count
    task automatic t_power_stop();
        wb(1'b1, OFS_COUNT, 32'h20);
        wb(1'b1, OFS_CTRL, ctrl(CS_DIV1, WGM_NORMAL, COM_OFF) | 32'h400);
        idle(40);
        wb(1'b0, OFS_COUNT, 32'h0);
        chk(q, 32'h20);
        wb(1'b1, OFS_CTRL, 32'h0);
        wb(1'b1, OFS_COUNT, 32'h10);
        idle(40);
        wb(1'b0, OFS_COUNT, 32'h0);
        chk(q, 32'h10);
        wb(1'b0, OFS_FLAG, 32'h0);
        chk(q, 32'h0);
        $display("test power and stop done");
    endtask
    // run across the wrap, both compare values passed, then mask and clear
    task automatic t_normal_irq();
        wb(1'b1, OFS_CMPA, 32'hF8);
        wb(1'b1, OFS_CMPB, 32'h03);
        wb(1'b1, OFS_COUNT, 32'hF0);
        wb(1'b1, OFS_CTRL, ctrl(CS_DIV1, WGM_NORMAL, COM_OFF));
        idle(40);
        wb(1'b1, OFS_CTRL, 32'h0);
        wb(1'b0, OFS_FLAG, 32'h0);
        chk(q, 32'h7);
        idle(20);
        wb(1'b0, OFS_FLAG, 32'h0);
        chk(q, 32'h7);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, OFS_MASK, 32'h1);
        idle(3);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, OFS_FCLR, 32'h1);
        idle(3);
        chk({31'h0, irq}, 32'h0);
        wb(1'b0, OFS_FLAG, 32'h0);
        chk(q, 32'h6);
        wb(1'b1, OFS_MASK, 32'h4);
        idle(3);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, OFS_FCLR, 32'h6);
        wb(1'b1, OFS_MASK, 32'h0);
        wb(1'b0, OFS_FLAG, 32'h0);
        chk(q, 32'h0);
        $display("test normal count and irq done");
    endtask
    // a write while counting every cycle must land, not be lost to the increment
    task automatic t_priority();
        wb(1'b1, OFS_CTRL, ctrl(CS_DIV1, WGM_NORMAL, COM_OFF));
        idle(5);
        wb(1'b1, OFS_COUNT, 32'h80);
        wb(1'b1, OFS_CTRL, 32'h0);
        wb(1'b0, OFS_COUNT, 32'h0);
        // written value, then three ticks until the stop write is taken
        chk(q, 32'h83);
        wb(1'b1, OFS_FCLR, 32'h7);
        $display("test write priority done");
    endtask
    // top taken from compare a: count never passes it, overflow never set
    task automatic t_ctc();
        int toggles = 0;
        logic last;
        wb(1'b1, OFS_COUNT, 32'h0);
        wb(1'b1, OFS_CMPA, 32'h0A);
        wb(1'b1, OFS_CTRL, ctrl(CS_DIV1, WGM_CTC, COM_TOGGLE));
        last = out_a;
        for (int i = 0; i < 120; i++) begin
            @(posedge i_clk);
            if (out_a !== last) toggles++;
            last = out_a;
        end
        wb(1'b1, OFS_CTRL, 32'h0);
        wb(1'b0, OFS_COUNT, 32'h0);
        chk({31'h0, q <= 32'h0A}, 32'h1);
        wb(1'b0, OFS_FLAG, 32'h0);
        chk(q & 32'h3, 32'h2);
        chk({31'h0, toggles >= 8 && toggles <= 12}, 32'h1);
        wb(1'b1, OFS_FCLR, 32'h7);
        $display("test compare top done");
    endtask
    // crystal selected: io clock alone must not count, each rising crystal edge counts once
    task automatic t_async();
        wb(1'b1, OFS_ASYNC, 32'h1);
        wb(1'b1, OFS_COUNT, 32'h0);
        wb(1'b1, OFS_CTRL, ctrl(CS_DIV1, WGM_NORMAL, COM_OFF));
        idle(30);
        wb(1'b0, OFS_COUNT, 32'h0);
        chk(q, 32'h0);
        for (int i = 0; i < 5; i++) begin
            @(posedge i_clk);
            xtal <= 1'b1;
            idle(4);
            xtal <= 1'b0;
            idle(4);
        end
        idle(10);
        wb(1'b0, OFS_COUNT, 32'h0);
        chk(q, 32'h5);
        wb(1'b0, OFS_ASYNC, 32'h0);
        chk(q, 32'h1);
        wb(1'b1, OFS_CTRL, 32'h0);
        wb(1'b1, OFS_ASYNC, 32'h0);
        $display("test crystal source done");
    endtask
    // prescaled sources: ticks over a 259-cycle window are the floor share or one more
    task automatic t_prescale();
        logic [2:0] code [4] = '{CS_DIV8, CS_DIV32, CS_DIV64, CS_DIV128};
        int div [4] = '{8, 32, 64, 128};
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, OFS_COUNT, 32'h0);
            wb(1'b1, OFS_CTRL, ctrl(code[i], WGM_NORMAL, COM_OFF));
            idle(256);
            wb(1'b1, OFS_CTRL, 32'h0);
            wb(1'b0, OFS_COUNT, 32'h0);
            chk({31'h0, q >= 259 / div[i] && q <= 259 / div[i] + 1}, 32'h1);
        end
        wb(1'b1, OFS_FCLR, 32'h7);
        $display("test prescaled source done");
    endtask
    // fast pwm, top at max: output b high share follows compare b over two periods
    task automatic t_pwm();
        int hi;
        int exp_hi;
        wb(1'b1, OFS_CMPB, 32'h40);
        wb(1'b1, OFS_COUNT, 32'h0);
        for (int j = 0; j < 2; j++) begin
            hi = 0;
            exp_hi = (j == 1) ? 384 : 128;
            wb(1'b1, OFS_CTRL, ctrl(CS_DIV1, WGM_FAST, COM_OFF)
                | (32'(j == 1 ? COM_SET : COM_CLEAR) << COMB_LSB));
            idle(300);
            for (int i = 0; i < 512; i++) begin
                @(posedge i_clk);
                if (out_b === 1'b1) hi++;
            end
            chk({31'h0, hi >= exp_hi - 8 && hi <= exp_hi + 8}, 32'h1);
        end
        wb(1'b1, OFS_CTRL, 32'h0);
        wb(1'b1, OFS_FCLR, 32'h7);
        $display("test fast pwm output done");
    endtask
    // enable low freezes the count; a mid-run reset brings back the defaults
    task automatic t_freeze();
        wb(1'b1, OFS_COUNT, 32'h0);
        wb(1'b1, OFS_CTRL, ctrl(CS_DIV1, WGM_NORMAL, COM_OFF));
        i_ce <= 1'b0;
        idle(20);
        i_ce <= 1'b1;
        wb(1'b1, OFS_CTRL, 32'h0);
        wb(1'b0, OFS_COUNT, 32'h0);
        chk(q, 32'h3);
        wb(1'b1, OFS_ASYNC, 32'h1);
        i_reset_n <= 1'b0;
        idle(2);
        i_reset_n <= 1'b1;
        wb(1'b0, OFS_ASYNC, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, OFS_COUNT, 32'h0);
        chk(q, 32'h0);
        $display("test enable freeze and reset done");
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        idle(16);
        i_reset_n <= 1'b1;
        t_reset();
        t_power_stop();
        t_normal_irq();
        t_priority();
        t_ctc();
        t_async();
        t_prescale();
        t_pwm();
        t_freeze();
        report_and_stop();
    end
endmodule
